// ### hw/bus_ctrl_pkg.sv
package bus_ctrl_pkg;

	// processor status codes as sampled on {line 2, line 1, line 0}
	localparam logic [2:0] CODE_ACK = 3'h0;
	localparam logic [2:0] CODE_IO_RD = 3'h1;
	localparam logic [2:0] CODE_IO_WR = 3'h2;
	localparam logic [2:0] CODE_HALT = 3'h3;
	localparam logic [2:0] CODE_FETCH = 3'h4;
	localparam logic [2:0] CODE_MEM_RD = 3'h5;
	localparam logic [2:0] CODE_MEM_WR = 3'h6;
	localparam logic [2:0] CODE_PASSIVE = 3'h7;

	localparam int CLK_PERIOD_NS = 10;
	localparam int GRANT_MIN_NS = 110;
	localparam int GRANT_DELAY_CYC = (GRANT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic CMD_RST = 1'h1;
	localparam logic ALE_RST = 1'h0;
	localparam logic DATA_EN_RST = 1'h0;
	localparam logic DIR_RST = 1'h0;
	localparam logic DUAL_RST = 1'h0;
	localparam logic STRAP_RST = 1'h0;
	localparam logic PREV_PASSIVE_RST = 1'h1;

	typedef enum logic [1:0] {
		phase_idle = 2'h0,
		phase_addr = 2'h1,
		phase_early = 2'h3,
		phase_late = 2'h2
	} phase_e;

endpackage

// ### hw/grant_timer.sv
`timescale 1ns/1ps
module grant_timer #(
	parameter int DELAY_CYC = bus_ctrl_pkg::GRANT_DELAY_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic bus_grant_n,
	output logic ready
);
	import bus_ctrl_pkg::*;

	localparam int W = $clog2(DELAY_CYC + 1);
	localparam logic [W-1:0] LIMIT = W'(DELAY_CYC);

	logic [W-1:0] count;
	wire at_limit = count == LIMIT;
	wire [W-1:0] next_count = at_limit ? count : count + 1'b1;

	// restart on every release so a short glitch low never counts as a grant
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= '0;
			ready <= 1'b0;
		end else if (bus_grant_n) begin
			count <= '0;
			ready <= 1'b0;
		end else begin
			count <= next_count;
			ready <= next_count == LIMIT;
		end
	end
endmodule

// ### hw/status_bus_command_controller.sv
`timescale 1ns/1ps
module status_bus_command_controller #(
	parameter int GRANT_DELAY = bus_ctrl_pkg::GRANT_DELAY_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic status_line_0,
	input wire logic status_line_1,
	input wire logic status_line_2,
	input wire logic bus_grant_n,
	input wire logic command_qualifier,
	input wire logic io_bus_mode_strap,
	output logic address_strobe,
	output logic data_transceiver_enable,
	output logic transceiver_direction,
	output logic cascade_or_periph_enable,
	output logic mem_read_n,
	output logic mem_read_oe,
	output logic mem_write_n,
	output logic mem_write_oe,
	output logic early_mem_write_n,
	output logic early_mem_write_oe,
	output logic io_read_n,
	output logic io_read_oe,
	output logic io_write_n,
	output logic io_write_oe,
	output logic early_io_write_n,
	output logic early_io_write_oe,
	output logic irq_acknowledge_n,
	output logic irq_acknowledge_oe
);
	import bus_ctrl_pkg::*;

	status_decode_if dec ();

	phase_e phase;
	phase_e next_phase;
	logic prev_passive;
	logic io_bus_mode;
	logic grant_ready;

	assign dec.code = {status_line_2, status_line_1, status_line_0};

	status_decoder u_decoder (
		.bus(dec.decoder)
	);

	grant_timer #(
		.DELAY_CYC(GRANT_DELAY)
	) u_grant (
		.clk(clk),
		.nrst(nrst),
		.bus_grant_n(bus_grant_n),
		.ready(grant_ready)
	);

	// strap is sampled every cycle after release, never loaded by the reset itself
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			io_bus_mode <= STRAP_RST;
		end else begin
			io_bus_mode <= io_bus_mode_strap;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prev_passive <= PREV_PASSIVE_RST;
		end else begin
			prev_passive <= dec.passive;
		end
	end

	// a new sequence only on a passive-to-active change of status
	wire start = prev_passive && !dec.passive;

	always_comb begin
		next_phase = phase;
		unique case (phase)
			phase_idle: begin
				next_phase = start ? phase_addr : phase_idle;
			end
			phase_addr: begin
				next_phase = dec.passive ? phase_idle : phase_early;
			end
			phase_early: begin
				next_phase = dec.passive ? phase_idle : phase_late;
			end
			phase_late: begin
				next_phase = dec.passive ? phase_idle : phase_late;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase <= phase_idle;
		end else begin
			phase <= next_phase;
		end
	end

	wire cmd_phase = (phase == phase_early) || (phase == phase_late);
	wire late_phase = phase == phase_late;
	// commands need an active code and an asserted qualifier
	wire cmd_on = cmd_phase && !dec.passive && command_qualifier;
	// memory always waits for the bus; I/O only in system-bus mode
	wire mem_ok = grant_ready;
	wire io_ok = io_bus_mode || grant_ready;
	wire io_kind = dec.io_rd || dec.io_wr || dec.ack;
	wire mem_kind = dec.mem_rd || dec.mem_wr;
	wire write_kind = dec.io_wr || dec.mem_wr;

	wire next_mem_read_n = !(cmd_on && dec.mem_rd && mem_ok);
	// early write has read timing; the normal write follows one phase later
	wire next_early_mem_write_n = !(cmd_on && dec.mem_wr && mem_ok);
	wire next_mem_write_n = !(cmd_on && late_phase && dec.mem_wr && mem_ok);
	wire next_io_read_n = !(cmd_on && dec.io_rd && io_ok);
	wire next_early_io_write_n = !(cmd_on && dec.io_wr && io_ok);
	wire next_io_write_n = !(cmd_on && late_phase && dec.io_wr && io_ok);
	wire next_irq_acknowledge_n = !(cmd_on && dec.ack && io_ok);

	// in I/O-bus mode the I/O transfers use the peripheral enable instead
	wire sys_xfer = mem_kind || (io_kind && !io_bus_mode);
	wire next_data_en = cmd_on && sys_xfer;
	wire next_dir = (phase != phase_idle || start) && write_kind && !dec.passive;
	wire next_ale = (phase == phase_idle) && start;
	wire next_periph_en_n = !(cmd_on && io_kind);
	// cascade address is gated while the address strobe is high
	wire next_cascade_en = (next_ale || phase == phase_addr) && dec.ack && next_phase == phase_addr;
	wire next_dual = io_bus_mode ? next_periph_en_n : next_cascade_en;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			address_strobe <= ALE_RST;
			data_transceiver_enable <= DATA_EN_RST;
			transceiver_direction <= DIR_RST;
			cascade_or_periph_enable <= DUAL_RST;
		end else begin
			address_strobe <= next_ale;
			data_transceiver_enable <= next_data_en;
			transceiver_direction <= next_dir;
			cascade_or_periph_enable <= next_dual;
		end
	end

	// inactive-high values are driven, not released, when the qualifier is low
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mem_read_n <= CMD_RST;
			mem_write_n <= CMD_RST;
			early_mem_write_n <= CMD_RST;
			io_read_n <= CMD_RST;
			io_write_n <= CMD_RST;
			early_io_write_n <= CMD_RST;
			irq_acknowledge_n <= CMD_RST;
		end else begin
			mem_read_n <= next_mem_read_n;
			mem_write_n <= next_mem_write_n;
			early_mem_write_n <= next_early_mem_write_n;
			io_read_n <= next_io_read_n;
			io_write_n <= next_io_write_n;
			early_io_write_n <= next_early_io_write_n;
			irq_acknowledge_n <= next_irq_acknowledge_n;
		end
	end

	// enables bypass the clock on purpose: losing the grant must release the bus at once
	wire mem_drive = grant_ready && !bus_grant_n;
	wire io_drive = io_bus_mode || mem_drive;

	assign mem_read_oe = mem_drive;
	assign mem_write_oe = mem_drive;
	assign early_mem_write_oe = mem_drive;
	assign io_read_oe = io_drive;
	assign io_write_oe = io_drive;
	assign early_io_write_oe = io_drive;
	assign irq_acknowledge_oe = io_drive;

	wire all_cmds_high = mem_read_n && mem_write_n && early_mem_write_n && io_read_n && io_write_n &&
		early_io_write_n && irq_acknowledge_n;

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (!nrst);

	sequence s_start;
		phase == phase_idle && start;
	endsequence

	sequence s_ale_pulse;
		address_strobe ##1 !address_strobe;
	endsequence

	property p_passive_high;
		dec.passive |=> all_cmds_high;
	endproperty
	a_passive_high: assert property (p_passive_high) else $error("command low after passive status");

	property p_ale_once;
		s_start |=> s_ale_pulse;
	endproperty
	a_ale_once: assert property (p_ale_once) else $error("address strobe not a one-cycle pulse");

	property p_ale_cause;
		$rose(address_strobe) |-> $past(prev_passive) && $past(phase) == phase_idle;
	endproperty
	a_ale_cause: assert property (p_ale_cause) else $error("address strobe without new cycle");

	property p_mem_read;
		s_start ##0 dec.mem_rd && command_qualifier && grant_ready ##1
			(dec.mem_rd && command_qualifier && grant_ready && !bus_grant_n) [*2] |=> !mem_read_n;
	endproperty
	a_mem_read: assert property (p_mem_read) else $error("memory read strobe missing");

	sequence s_mem_write_early;
		phase == phase_early && dec.mem_wr && command_qualifier && grant_ready;
	endsequence

	property p_mem_write_order;
		s_mem_write_early |=> !early_mem_write_n && mem_write_n;
	endproperty
	a_mem_write_order: assert property (p_mem_write_order) else $error("memory writes out of order");

	property p_io_write_order;
		phase == phase_early && dec.io_wr && command_qualifier && io_ok ##1
			dec.io_wr && command_qualifier && io_ok |=> !early_io_write_n ##0 !io_write_n;
	endproperty
	a_io_write_order: assert property (p_io_write_order) else $error("io write strobe missing");

	// run of low grant samples kept apart from the timer, so any delay setting up to 255 cycles is judged
	logic [7:0] low_run;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			low_run <= '0;
		end else if (bus_grant_n) begin
			low_run <= '0;
		end else if (low_run != 8'hFF) begin
			low_run <= low_run + 8'h01;
		end
	end

	property p_grant_not_early;
		mem_read_oe |-> int'(low_run) >= GRANT_DELAY;
	endproperty
	a_grant_not_early: assert property (p_grant_not_early) else $error("commands enabled too soon");

	property p_grant_late;
		!bus_grant_n && int'(low_run) >= GRANT_DELAY |-> mem_read_oe && early_mem_write_oe;
	endproperty
	a_grant_late: assert property (p_grant_late) else $error("commands not enabled after grant");

	property p_release_now;
		bus_grant_n && !io_bus_mode |-> !mem_read_oe && !io_read_oe && !irq_acknowledge_oe;
	endproperty
	a_release_now: assert property (p_release_now) else $error("drivers not released");

	property p_io_bus_io_on;
		io_bus_mode |-> io_read_oe && io_write_oe && early_io_write_oe && irq_acknowledge_oe;
	endproperty
	a_io_bus_io_on: assert property (p_io_bus_io_on) else $error("io commands gated in io-bus mode");

	property p_qualifier;
		!command_qualifier |=> all_cmds_high && !data_transceiver_enable &&
			(!io_bus_mode || cascade_or_periph_enable || !$past(io_bus_mode));
	endproperty
	a_qualifier: assert property (p_qualifier) else $error("outputs active with qualifier low");

	property p_direction;
		s_start ##0 dec.mem_wr |=> transceiver_direction;
	endproperty
	a_direction: assert property (p_direction) else $error("direction not transmit on write");

	property p_read_receive;
		dec.mem_rd || dec.io_rd |=> !transceiver_direction;
	endproperty
	a_read_receive: assert property (p_read_receive) else $error("direction not receive on read");

	property p_cascade;
		s_start ##0 dec.ack && !io_bus_mode ##1 dec.ack && io_bus_mode == $past(io_bus_mode) |-> cascade_or_periph_enable;
	endproperty
	a_cascade: assert property (p_cascade) else $error("cascade enable missing");

	property p_io_read;
		phase == phase_early && dec.io_rd && command_qualifier && io_ok |=> !io_read_n;
	endproperty
	a_io_read: assert property (p_io_read) else $error("io read strobe missing");

	property p_ack;
		phase == phase_early && dec.ack && command_qualifier && io_ok |=> !irq_acknowledge_n;
	endproperty
	a_ack: assert property (p_ack) else $error("acknowledge strobe missing");

	property p_early_io_write;
		phase == phase_early && dec.io_wr && command_qualifier && io_ok |=> !early_io_write_n && io_write_n;
	endproperty
	a_early_io_write: assert property (p_early_io_write) else $error("early io write not ahead of io write");

	property p_mem_write_late;
		phase == phase_late && dec.mem_wr && command_qualifier && grant_ready |=> !mem_write_n;
	endproperty
	a_mem_write_late: assert property (p_mem_write_late) else $error("memory write strobe missing");

	property p_data_enable;
		phase == phase_early && dec.mem_rd && command_qualifier |=> data_transceiver_enable;
	endproperty
	a_data_enable: assert property (p_data_enable) else $error("data enable missing in data phase");

	property p_periph_enable;
		phase == phase_early && dec.io_rd && command_qualifier && io_bus_mode |=> !cascade_or_periph_enable;
	endproperty
	a_periph_enable: assert property (p_periph_enable) else $error("peripheral enable missing");

	property p_grant_hold;
		!grant_ready && !io_bus_mode |=> all_cmds_high;
	endproperty
	a_grant_hold: assert property (p_grant_hold) else $error("command issued before grant");

	property p_strap;
		$past(nrst) |-> io_bus_mode == $past(io_bus_mode_strap);
	endproperty
	a_strap: assert property (p_strap) else $error("mode does not follow strap");

	property p_halt_quiet;
		dec.halt |=> all_cmds_high;
	endproperty
	a_halt_quiet: assert property (p_halt_quiet) else $error("command issued on halt");

endmodule

// ### hw/status_decode_if.sv
`timescale 1ns/1ps
interface status_decode_if;
	logic [2:0] code;
	logic ack;
	logic io_rd;
	logic io_wr;
	logic halt;
	logic mem_rd;
	logic mem_wr;
	logic passive;

	modport decoder (
		input code,
		output ack,
		output io_rd,
		output io_wr,
		output halt,
		output mem_rd,
		output mem_wr,
		output passive
	);

	modport user (
		output code,
		input ack,
		input io_rd,
		input io_wr,
		input halt,
		input mem_rd,
		input mem_wr,
		input passive
	);
endinterface

// ### hw/status_decoder.sv
`timescale 1ns/1ps
module status_decoder (
	status_decode_if.decoder bus
);
	import bus_ctrl_pkg::*;

	assign bus.ack = bus.code == CODE_ACK;
	assign bus.io_rd = bus.code == CODE_IO_RD;
	assign bus.io_wr = bus.code == CODE_IO_WR;
	assign bus.halt = bus.code == CODE_HALT;
	// code fetch and data read give the same strobe
	assign bus.mem_rd = (bus.code == CODE_FETCH) || (bus.code == CODE_MEM_RD);
	assign bus.mem_wr = bus.code == CODE_MEM_WR;
	assign bus.passive = bus.code == CODE_PASSIVE;
endmodule

// ### verification/status_arb_model.sv
`timescale 1ns/1ps
module status_arb_model (
	output logic status_line_0,
	output logic status_line_1,
	output logic status_line_2,
	output logic bus_grant_n
);
	initial begin
		{status_line_2, status_line_1, status_line_0} = 3'h7;
		bus_grant_n = 1'h1;
	end
	// caller returns to passive between cycles
	task put_code(input logic [2:0] c);
		{status_line_2, status_line_1, status_line_0} <= c;
	endtask
	// arbiter pulls low while the bus is free
	task put_grant(input logic free);
		bus_grant_n <= ~free;
	endtask
endmodule

// ### verification/tb_status_bus_command_controller.sv
`timescale 1ns/1ps
module tb_status_bus_command_controller;
	import bus_ctrl_pkg::*;
	localparam int GD = 2;
	logic clk, nrst, qual, strap;
	wire st0, st1, st2, gnt_n, ale, data_en, dir, dual;
	wire [6:0] cmd, oe;
	int n_fail, num_checks, cyc;

	status_arb_model cpu_u (.status_line_0(st0), .status_line_1(st1), .status_line_2(st2), .bus_grant_n(gnt_n));

	status_bus_command_controller #(.GRANT_DELAY(GD)) dut_u (
		.clk(clk), .nrst(nrst), .status_line_0(st0), .status_line_1(st1), .status_line_2(st2),
		.bus_grant_n(gnt_n), .command_qualifier(qual), .io_bus_mode_strap(strap),
		.address_strobe(ale), .data_transceiver_enable(data_en), .transceiver_direction(dir),
		.cascade_or_periph_enable(dual),
		.mem_read_n(cmd[6]), .mem_read_oe(oe[6]), .mem_write_n(cmd[5]), .mem_write_oe(oe[5]),
		.early_mem_write_n(cmd[4]), .early_mem_write_oe(oe[4]), .io_read_n(cmd[3]), .io_read_oe(oe[3]),
		.io_write_n(cmd[2]), .io_write_oe(oe[2]), .early_io_write_n(cmd[1]), .early_io_write_oe(oe[1]),
		.irq_acknowledge_n(cmd[0]), .irq_acknowledge_oe(oe[0])
	);

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// a hang is cut short well past the expected run length
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			stop_test();
		end
	end

	task automatic chk_v(input string nm, input logic [6:0] e, input logic [6:0] s);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chk_b(input string nm, input logic e, input logic s);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %b seen %b", nm, e, s);
		end
	endtask

	// bit order {mem rd, mem wr, early mem wr, io rd, io wr, early io wr, ack}
	function automatic logic [6:0] exp_cmd(input logic [2:0] c, input logic late, input logic g);
		logic [6:0] r;
		logic io_ok;
		r = 7'h7F;
		io_ok = g | strap;
		if (qual) begin
			case (c)
				3'h0: r[0] = ~io_ok;
				3'h1: r[3] = ~io_ok;
				3'h2: begin
					r[1] = ~io_ok;
					r[2] = ~(io_ok & late);
				end
				3'h4, 3'h5: r[6] = ~g;
				3'h6: begin
					r[4] = ~g;
					r[5] = ~(g & late);
				end
				default: ;
			endcase
		end
		return r;
	endfunction

	task automatic run(input logic [2:0] c, input logic g);
		logic wr, iot;
		wr = (c == 3'h2) || (c == 3'h6);
		iot = c < 3'h3;
		@(posedge clk);
		cpu_u.put_code(c);
		@(posedge clk);
		#1;
		chk_b("strobe", 1'h1, ale);
		chk_b("direction", wr, dir);
		chk_b("dual c1", strap | (c == 3'h0), dual);
		chk_v("cmd c1", 7'h7F, cmd);
		@(posedge clk);
		#1;
		chk_b("strobe end", 1'h0, ale);
		chk_b("dual c2", strap, dual);
		@(posedge clk);
		#1;
		chk_v("cmd early", exp_cmd(c, 1'h0, g), cmd);
		chk_v("oe", {{3{g}}, {4{g | strap}}}, oe);
		if (g) chk_b("data enable", qual & (c != 3'h3) & !(strap & iot), data_en);
		chk_b("dual c3", strap & !(qual & iot), dual);
		@(posedge clk);
		#1;
		chk_v("cmd late", exp_cmd(c, 1'h1, g), cmd);
		@(posedge clk);
		cpu_u.put_code(3'h7);
		@(posedge clk);
		#1;
		chk_v("cmd idle", 7'h7F, cmd);
		chk_b("data enable idle", 1'h0, data_en);
	endtask

	task set_bus(input logic g);
		@(posedge clk);
		cpu_u.put_grant(g);
		repeat (GD + 2) @(posedge clk);
	endtask

	task set_strap(input logic m);
		@(posedge clk);
		strap <= m;
		repeat (2) @(posedge clk);
	endtask

	task t_grant;
		@(posedge clk);
		cpu_u.put_grant(1'h1);
		repeat (GD - 1) begin
			@(posedge clk);
			#1;
			chk_v("oe wait", 7'h00, oe);
		end
		@(posedge clk);
		#1;
		chk_v("oe granted", 7'h7F, oe);
		@(posedge clk);
		cpu_u.put_grant(1'h0);
		#1;
		chk_v("oe dropped", 7'h00, oe);
		$display("grant timing done");
	endtask

	task t_no_grant;
		run(3'h1, 1'h0);
		run(3'h5, 1'h0);
		set_strap(1'h1);
		run(3'h1, 1'h0);
		run(3'h2, 1'h0);
		run(3'h0, 1'h0);
		run(3'h5, 1'h0);
		$display("no grant done");
	endtask

	task t_all_codes;
		set_bus(1'h1);
		for (int m = 1; m >= 0; m--) begin
			set_strap(m[0]);
			for (int c = 0; c < 7; c++) run(c[2:0], 1'h1);
		end
		$display("all codes done");
	endtask

	task t_qualifier;
		@(posedge clk);
		qual <= 1'h0;
		run(3'h6, 1'h1);
		run(3'h1, 1'h1);
		set_strap(1'h1);
		run(3'h2, 1'h1);
		@(posedge clk);
		qual <= 1'h1;
		$display("qualifier done");
	endtask

	initial begin
		nrst = 1'h0;
		qual = 1'h1;
		strap = 1'h0;
		n_fail = 0;
		num_checks = 0;
		cyc = 0;
		repeat (5) @(posedge clk);
		#1;
		chk_v("reset cmd", 7'h7F, cmd);
		chk_v("reset oe", 7'h00, oe);
		chk_b("reset strobe", 1'h0, ale);
		repeat (5) @(posedge clk);
		nrst <= 1'h1;
		repeat (2) @(posedge clk);
		t_grant();
		t_no_grant();
		t_all_codes();
		t_qualifier();
		stop_test();
	end
endmodule
